// ### verilog/dcvc_top.sv
// Function
// - check core supply against VID-derived limits
// - window checks run beside fixed-limit checks
// - four VID modes, three regulator families
// - rely on VID changes at most every 5 us
// - ignore transient codes from line skew
// - average VID voltage over 1.5 ms window
// - compare against averaged, not instantaneous, VID
// - upper limit is average plus upper offset
// - lower limit is average minus lower offset
// - reading outside window raises channel error
// - compare once per 100 ms period
// - output-off code in window skips check
// - skip upper check above 1.5875 V
// - oldest mode: pins are inputs in status
// - other modes: pins are VID bit six
// - route aux channels to fan control
// - routed aux reading has MSB inverted
module dcvc_top #(
  parameter int PERIOD_CYC = dcvc_pkg::PERIOD_CYC_DEF,
  parameter int WIN_CYC = dcvc_pkg::WIN_CYC_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dcvc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [dcvc_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // processor identification pins
  input wire logic [5:0] cpu1_voltage_id_lines,
  input wire logic [5:0] cpu2_voltage_id_lines,
  input wire logic [1:0] voltage_id_bit_six,
  // converter results
  input wire logic conv_valid,
  input wire dcvc_pkg::dcvc_conv_s conv,
  // fan control and interrupt
  output dcvc_pkg::dcvc_fan_s fan_temp,
  output logic irq
);

  localparam int SAMP_CYC = WIN_CYC >> dcvc_pkg::AVG_LOG2;

  dcvc_pkg::dcvc_state_s st_ff;
  dcvc_pkg::dcvc_state_s nxt_st;

  // byte-lane merge of a write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // nominal voltage of a code, 6.25 mV units, clamped at zero
  function automatic logic [7:0] vid_volts(input dcvc_pkg::dcvc_mode_e m, input logic [6:0] code);
    logic [8:0] top;
    logic [8:0] dec;
    top = dcvc_pkg::TOP_NEW8;
    dec = {2'b00, code};
    case (m)
      dcvc_pkg::MODE_OLD: begin
        top = dcvc_pkg::TOP_OLD;
        dec = {2'b00, code[5:0], 1'b0}; // 12.5 mV steps
      end
      dcvc_pkg::MODE_EXT: begin
        top = dcvc_pkg::TOP_EXT;
      end
      dcvc_pkg::MODE_NEW7: begin
        top = dcvc_pkg::TOP_NEW7;
      end
      default: begin
        top = dcvc_pkg::TOP_NEW8;
      end
    endcase
    if (top > dec) begin
      return 8'(top - dec);
    end
    return 8'h00;
  endfunction

  // code that asks the regulator to switch off
  function automatic logic vid_off(input dcvc_pkg::dcvc_mode_e m, input logic [6:0] code);
    case (m)
      dcvc_pkg::MODE_OLD: return code[5:0] == dcvc_pkg::OFF_OLD;
      dcvc_pkg::MODE_EXT: return code == dcvc_pkg::OFF_EXT;
      dcvc_pkg::MODE_NEW7: return code == dcvc_pkg::OFF_NEW;
      default: return (code == dcvc_pkg::OFF_NEW) || (code == dcvc_pkg::OFF_EXT);
    endcase
  endfunction

  // aux code as seen by fan control
  function automatic logic [7:0] aux_fmt(input logic route, input logic [7:0] raw);
    return route ? {~raw[7], raw[6:0]} : raw;
  endfunction

  // handshakes straight from the holding flags
  assign s_axi_awready = !st_ff.aw_hold;
  assign s_axi_wready = !st_ff.w_hold;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign fan_temp = st_ff.fan;
  assign irq = st_ff.irq;

  // whole next state
  always_comb begin
    logic [1:0][6:0] raw;
    logic [dcvc_pkg::ST_W-1:0] set;
    logic [dcvc_pkg::ST_W-1:0] clr;
    logic [31:0] img;
    logic [31:0] rd;
    logic [1:0] gpi;
    logic [8:0] up_sum;
    logic hi;
    logic lo;
    raw = '0;
    set = '0;
    clr = '0;
    img = '0;
    rd = '0;
    gpi = '0;
    up_sum = '0;
    hi = 1'b0;
    lo = 1'b0;
    nxt_st = st_ff;

    // accept address and data in either order
    if (s_axi_awvalid && !st_ff.aw_hold) begin
      nxt_st.aw_hold = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.w_hold) begin
      nxt_st.w_hold = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // write once both halves are held and no response is pending
    if (st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid) begin
      nxt_st.aw_hold = 1'b0;
      nxt_st.w_hold = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = dcvc_pkg::RESP_OKAY;
      case ({st_ff.aw_addr[dcvc_pkg::ADDR_W-1:2], 2'b00})
        dcvc_pkg::REG_CTRL: begin
          img = merge({27'h0, st_ff.fan.route_b, st_ff.fan.route_a, st_ff.mode, st_ff.en},
                      st_ff.w_data, st_ff.w_strb);
          nxt_st.en = img[dcvc_pkg::CTRL_EN];
          nxt_st.mode = dcvc_pkg::dcvc_mode_e'(img[dcvc_pkg::CTRL_MODE +: 2]);
          nxt_st.fan.route_a = img[dcvc_pkg::CTRL_ROUTE_A];
          nxt_st.fan.route_b = img[dcvc_pkg::CTRL_ROUTE_B];
        end
        dcvc_pkg::REG_OFS1: begin
          img = merge({16'h0, st_ff.ofs_lo[0], st_ff.ofs_up[0]}, st_ff.w_data, st_ff.w_strb);
          nxt_st.ofs_up[0] = img[7:0];
          nxt_st.ofs_lo[0] = img[dcvc_pkg::OFS_LO +: 8];
        end
        dcvc_pkg::REG_OFS2: begin
          img = merge({16'h0, st_ff.ofs_lo[1], st_ff.ofs_up[1]}, st_ff.w_data, st_ff.w_strb);
          nxt_st.ofs_up[1] = img[7:0];
          nxt_st.ofs_lo[1] = img[dcvc_pkg::OFS_LO +: 8];
        end
        dcvc_pkg::REG_IRQ_EN: begin
          img = merge({29'h0, st_ff.ien}, st_ff.w_data, st_ff.w_strb);
          nxt_st.ien = img[dcvc_pkg::ST_W-1:0];
        end
        dcvc_pkg::REG_IRQ_CLR: begin
          img = merge(32'h0000_0000, st_ff.w_data, st_ff.w_strb);
          clr = img[dcvc_pkg::ST_W-1:0];
        end
        // read-only registers take the write and ignore it
        dcvc_pkg::REG_AVG, dcvc_pkg::REG_MGMT_ERR, dcvc_pkg::REG_HOST_ERR,
        dcvc_pkg::REG_IRQ_STAT, dcvc_pkg::REG_AUX: begin
          nxt_st.bresp = dcvc_pkg::RESP_OKAY;
        end
        default: begin
          nxt_st.bresp = dcvc_pkg::RESP_SLVERR;
        end
      endcase
    end

    // general inputs show only in the oldest mode
    gpi = (st_ff.mode == dcvc_pkg::MODE_OLD) ? voltage_id_bit_six : 2'b00;

    // read path, one word per request
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = dcvc_pkg::RESP_OKAY;
      case ({s_axi_araddr[dcvc_pkg::ADDR_W-1:2], 2'b00})
        dcvc_pkg::REG_CTRL: rd = {27'h0, st_ff.fan.route_b, st_ff.fan.route_a, st_ff.mode, st_ff.en};
        dcvc_pkg::REG_OFS1: rd = {16'h0, st_ff.ofs_lo[0], st_ff.ofs_up[0]};
        dcvc_pkg::REG_OFS2: rd = {16'h0, st_ff.ofs_lo[1], st_ff.ofs_up[1]};
        dcvc_pkg::REG_AVG: rd = {16'h0, st_ff.avg[1], st_ff.avg[0]};
        // both error views carry the same bits for each side of the system
        dcvc_pkg::REG_MGMT_ERR, dcvc_pkg::REG_HOST_ERR: begin
          rd = {26'h0, st_ff.skip_up, gpi, st_ff.err_last};
        end
        dcvc_pkg::REG_IRQ_STAT: rd = {29'h0, st_ff.stat};
        dcvc_pkg::REG_IRQ_EN: rd = {29'h0, st_ff.ien};
        dcvc_pkg::REG_IRQ_CLR: rd = 32'h0000_0000;
        dcvc_pkg::REG_AUX: rd = {16'h0, st_ff.fan.temp_b, st_ff.fan.temp_a};
        default: begin
          rd = 32'h0000_0000;
          nxt_st.rresp = dcvc_pkg::RESP_SLVERR;
        end
      endcase
      nxt_st.rdata = rd;
    end

    // latch converter results; aux readings formatted on the way
    if (conv_valid) begin
      nxt_st.core[0] = conv.core1;
      nxt_st.core[1] = conv.core2;
      nxt_st.fan.temp_a = aux_fmt(nxt_st.fan.route_a, conv.aux_a);
      nxt_st.fan.temp_b = aux_fmt(nxt_st.fan.route_b, conv.aux_b);
    end

    // assemble codes; bit six joins the code outside the oldest mode
    raw[0] = (st_ff.mode == dcvc_pkg::MODE_OLD) ? {1'b0, cpu1_voltage_id_lines}
                                                : {voltage_id_bit_six[0], cpu1_voltage_id_lines};
    raw[1] = (st_ff.mode == dcvc_pkg::MODE_OLD) ? {1'b0, cpu2_voltage_id_lines}
                                                : {voltage_id_bit_six[1], cpu2_voltage_id_lines};

    // a code counts only once stable for the skew time, well inside
    // the 5 us spacing of real steps, so no genuine step is missed
    for (int i = 0; i < 2; i++) begin
      if (raw[i] != st_ff.vid_cand[i]) begin
        nxt_st.vid_cand[i] = raw[i];
        nxt_st.skew_cnt[i] = 8'h00;
      end else if (st_ff.skew_cnt[i] == 8'(dcvc_pkg::SKEW_CYC - 1)) begin
        nxt_st.vid_ok[i] = st_ff.vid_cand[i];
      end else begin
        nxt_st.skew_cnt[i] = st_ff.skew_cnt[i] + 8'h01;
      end
    end

    // free-running measurement period
    if (st_ff.period_cnt == 32'(PERIOD_CYC - 1)) begin
      nxt_st.period_cnt = 32'h0000_0000;
    end else begin
      nxt_st.period_cnt = st_ff.period_cnt + 32'h0000_0001;
    end

    // window sits at the end of each period, comparison follows it
    case (st_ff.phase)
      dcvc_pkg::PH_WAIT: begin
        if (st_ff.en && st_ff.period_cnt == 32'(PERIOD_CYC - WIN_CYC - 1)) begin
          nxt_st.phase = dcvc_pkg::PH_WIN;
          nxt_st.acc = '0;
          nxt_st.off_seen = 2'b00;
          nxt_st.samp_cnt = 32'h0000_0000;
          nxt_st.nsamp = 9'h000;
        end
      end
      dcvc_pkg::PH_WIN: begin
        for (int i = 0; i < 2; i++) begin
          if (vid_off(st_ff.mode, st_ff.vid_ok[i])) begin
            nxt_st.off_seen[i] = 1'b1;
          end
        end
        if (st_ff.samp_cnt == 32'(SAMP_CYC - 1)) begin
          nxt_st.samp_cnt = 32'h0000_0000;
          nxt_st.nsamp = st_ff.nsamp + 9'h001;
          for (int i = 0; i < 2; i++) begin
            nxt_st.acc[i] = st_ff.acc[i] + {8'h00, vid_volts(st_ff.mode, st_ff.vid_ok[i])};
          end
          if (st_ff.nsamp == 9'(dcvc_pkg::AVG_SAMPLES - 1)) begin
            nxt_st.phase = dcvc_pkg::PH_CMP;
          end
        end else begin
          nxt_st.samp_cnt = st_ff.samp_cnt + 32'h0000_0001;
        end
        if (!st_ff.en) begin
          nxt_st.phase = dcvc_pkg::PH_WAIT;
        end
      end
      dcvc_pkg::PH_CMP: begin
        // fixed-limit checks live elsewhere and are untouched here
        for (int i = 0; i < 2; i++) begin
          nxt_st.avg[i] = st_ff.acc[i][15:8];
          up_sum = {1'b0, nxt_st.avg[i]} + {1'b0, st_ff.ofs_up[i]};
          nxt_st.skip_up[i] = up_sum > dcvc_pkg::UPPER_CEIL;
          hi = !nxt_st.skip_up[i] && ({1'b0, st_ff.core[i]} > up_sum);
          lo = (nxt_st.avg[i] >= st_ff.ofs_lo[i]) &&
               (st_ff.core[i] < nxt_st.avg[i] - st_ff.ofs_lo[i]);
          nxt_st.err_last[i] = !st_ff.off_seen[i] && (hi || lo);
          set[i] = nxt_st.err_last[i];
        end
        set[dcvc_pkg::ST_DONE] = 1'b1;
        nxt_st.phase = dcvc_pkg::PH_WAIT;
      end
      default: begin
        nxt_st.phase = dcvc_pkg::PH_WAIT;
      end
    endcase

    // sticky status: a new event beats a clear in the same cycle
    nxt_st.stat = (st_ff.stat & ~clr) | set;
    nxt_st.irq = |(nxt_st.stat & nxt_st.ien);
  end

  // single state register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// ### verilog/dcvc_pkg.sv
package dcvc_pkg;

  // clock and timing
  localparam int CLK_MHZ = 200;
  localparam int PERIOD_MS = 100;
  localparam int PERIOD_CYC_DEF = PERIOD_MS * 1000 * CLK_MHZ;
  localparam int WIN_US = 1500;
  localparam int WIN_CYC_DEF = WIN_US * CLK_MHZ;
  localparam int SKEW_NS = 500;
  localparam int SKEW_CYC = (SKEW_NS * CLK_MHZ + 999) / 1000;
  localparam int VID_STEP_US = 5;
  localparam int VID_STEP_CYC = VID_STEP_US * CLK_MHZ;
  localparam int AVG_LOG2 = 8;
  localparam int AVG_SAMPLES = 1 << AVG_LOG2;

  // voltages in 6.25 mV units; 254 units is 1.5875 V
  localparam logic [8:0] UPPER_CEIL = 9'h0FE;
  localparam logic [8:0] TOP_OLD = 9'h0FE;
  localparam logic [8:0] TOP_EXT = 9'h0FE;
  localparam logic [8:0] TOP_NEW7 = 9'h0FE;
  localparam logic [8:0] TOP_NEW8 = 9'h0FF;
  localparam logic [5:0] OFF_OLD = 6'h3F;
  localparam logic [6:0] OFF_EXT = 7'h7F;
  localparam logic [6:0] OFF_NEW = 7'h00;

  // register byte offsets
  localparam int ADDR_W = 6;
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_OFS1 = 6'h04;
  localparam logic [5:0] REG_OFS2 = 6'h08;
  localparam logic [5:0] REG_AVG = 6'h0C;
  localparam logic [5:0] REG_MGMT_ERR = 6'h10;
  localparam logic [5:0] REG_HOST_ERR = 6'h14;
  localparam logic [5:0] REG_IRQ_STAT = 6'h18;
  localparam logic [5:0] REG_IRQ_EN = 6'h1C;
  localparam logic [5:0] REG_IRQ_CLR = 6'h20;
  localparam logic [5:0] REG_AUX = 6'h24;

  // field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_ROUTE_A = 3;
  localparam int CTRL_ROUTE_B = 4;
  localparam int OFS_LO = 8;
  localparam int ERR_GPI = 2;
  localparam int ERR_SKIP = 4;
  localparam int ST_DONE = 2;
  localparam int ST_W = 3;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_OLD = 2'b00,
    MODE_EXT = 2'b01,
    MODE_NEW7 = 2'b10,
    MODE_NEW8 = 2'b11
  } dcvc_mode_e;

  typedef enum logic [1:0] {
    PH_WAIT = 2'b00,
    PH_WIN = 2'b01,
    PH_CMP = 2'b10
  } dcvc_phase_e;

  // one converter result set, all 8-bit codes
  typedef struct packed {
    logic [7:0] core1;
    logic [7:0] core2;
    logic [7:0] aux_a;
    logic [7:0] aux_b;
  } dcvc_conv_s;

  // auxiliary readings toward fan control
  typedef struct packed {
    logic route_a;
    logic route_b;
    logic [7:0] temp_a;
    logic [7:0] temp_b;
  } dcvc_fan_s;

  typedef struct packed {
    logic aw_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic en;
    dcvc_mode_e mode;
    logic [1:0][7:0] ofs_up;
    logic [1:0][7:0] ofs_lo;
    logic [1:0][6:0] vid_cand;
    logic [1:0][7:0] skew_cnt;
    logic [1:0][6:0] vid_ok;
    logic [1:0][15:0] acc;
    logic [1:0][7:0] avg;
    logic [1:0] off_seen;
    logic [1:0] err_last;
    logic [1:0] skip_up;
    logic [1:0][7:0] core;
    dcvc_phase_e phase;
    logic [31:0] period_cnt;
    logic [31:0] samp_cnt;
    logic [8:0] nsamp;
    logic [ST_W-1:0] stat;
    logic [ST_W-1:0] ien;
    logic irq;
    dcvc_fan_s fan;
  } dcvc_state_s;

endpackage

// ### tb/dcvc_props.sv
module dcvc_props #(
  parameter int PERIOD_CYC = 2000,
  parameter int WIN_CYC = 512
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // converter, fan and interrupt
  input wire logic conv_valid,
  input wire dcvc_pkg::dcvc_conv_s conv,
  input wire dcvc_pkg::dcvc_fan_s fan_temp,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // outputs idle after every reset
  reset_idle_a: assert property ($fell(srst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
    else $error("bus answer or interrupt active after reset");
  // answers stand until taken
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late or second read accepted");
  addr_refused_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second address accepted");
  data_refused_a: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("second data word accepted");
  error_zero_a: assert property (s_axi_rvalid && s_axi_rresp == dcvc_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  // a routed reading appears with its top bit inverted
  temp_a_signed_a: assert property (conv_valid && fan_temp.route_a ##1 fan_temp.route_a |->
    fan_temp.temp_a == ($past(conv.aux_a) ^ 8'h80)) else $error("aux a temperature wrong");
  temp_b_signed_a: assert property (conv_valid && fan_temp.route_b ##1 fan_temp.route_b |->
    fan_temp.temp_b == ($past(conv.aux_b) ^ 8'h80)) else $error("aux b temperature wrong");
endmodule

bind dcvc_top dcvc_props #(.PERIOD_CYC(PERIOD_CYC), .WIN_CYC(WIN_CYC)) props_u (.clk_sys, .srst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .conv_valid, .conv, .fan_temp, .irq);

// ### tb/dcvc_proc_model.sv
module dcvc_proc_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // wanted codes and readings
  input wire logic [5:0] tgt1,
  input wire logic [5:0] tgt2,
  input wire logic [7:0] core1,
  input wire logic [7:0] core2,
  input wire logic [7:0] aux_a,
  input wire logic [7:0] aux_b,
  // processor and converter side
  output logic [5:0] cpu1_voltage_id_lines,
  output logic [5:0] cpu2_voltage_id_lines,
  output logic conv_valid,
  output dcvc_pkg::dcvc_conv_s conv,
  output logic settled
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cur1, cur2, nx1, nx2;
  int step_cnt = 0;
  int glitch_cnt = 0;
  int conv_cnt = 0;
  // next code one step toward the wanted one
  assign nx1 = (cur1 < tgt1) ? cur1 + 6'h01 : (cur1 > tgt1) ? cur1 - 6'h01 : cur1;
  assign nx2 = (cur2 < tgt2) ? cur2 + 6'h01 : (cur2 > tgt2) ? cur2 - 6'h01 : cur2;
  assign settled = cur1 == tgt1 && cur2 == tgt2 && glitch_cnt == 0;
  // line skew shows a transient code for 20 cycles before each step lands
  always @(posedge clk_sys) begin
    if (srst) begin
      cur1 <= tgt1;
      cur2 <= tgt2;
      cpu1_voltage_id_lines <= tgt1;
      cpu2_voltage_id_lines <= tgt2;
      step_cnt <= 0;
      glitch_cnt <= 0;
    end else begin
      step_cnt <= step_cnt + 1;
      if (glitch_cnt > 1) glitch_cnt <= glitch_cnt - 1;
      if (glitch_cnt == 1) begin
        cpu1_voltage_id_lines <= cur1;
        cpu2_voltage_id_lines <= cur2;
        glitch_cnt <= 0;
      end
      if (step_cnt >= dcvc_pkg::VID_STEP_CYC && glitch_cnt == 0 && !settled) begin
        cur1 <= nx1;
        cur2 <= nx2;
        cpu1_voltage_id_lines <= cur1 | nx1;
        cpu2_voltage_id_lines <= cur2 | nx2;
        glitch_cnt <= 20;
        step_cnt <= 0;
      end
    end
  end
  // result every 40 cycles; payload inverted between pulses so stale use shows
  always @(posedge clk_sys) begin
    conv_cnt <= (srst || conv_cnt >= 39) ? 0 : conv_cnt + 1;
    conv_valid <= !srst && conv_cnt == 39;
    conv <= (conv_cnt == 39) ? {core1, core2, aux_a, aux_b} : ~{core1, core2, aux_a, aux_b};
  end
endmodule

// ### tb/dcvc_top_bench.sv
module dcvc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CEIL = 95000;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00, tgt1 = 6'h01, tgt2 = 6'h01;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] voltage_id_bit_six = 2'h0;
  logic [7:0] core1 = 8'h00, core2 = 8'h00, aux_a = 8'h00, aux_b = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_valid, irq, settled;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic [5:0] cpu1_voltage_id_lines, cpu2_voltage_id_lines;
  dcvc_pkg::dcvc_conv_s conv;
  dcvc_pkg::dcvc_fan_s fan_temp;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  integer seed = 21;

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  dcvc_top #(.PERIOD_CYC(2000), .WIN_CYC(512)) dut_u (.clk_sys, .srst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .cpu1_voltage_id_lines, .cpu2_voltage_id_lines, .voltage_id_bit_six, .conv_valid, .conv,
    .fan_temp, .irq);

  dcvc_proc_model model_u (.clk_sys, .srst, .tgt1, .tgt2, .core1, .core2, .aux_a, .aux_b,
    .cpu1_voltage_id_lines, .cpu2_voltage_id_lines, .conv_valid, .conv, .settled);

  task complete_run;
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // handshakes sampled at the falling edge, released after the next rising one
  task wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, tb;
    int n;
    tb = 1'b0;
    rs = 2'h3;
    @(posedge clk_sys);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40 && !tb; n++) begin
      @(negedge clk_sys);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid === 1'b1;
      rs = s_axi_bresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
  endtask

  task rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tr;
    int n;
    tr = 1'b0;
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40 && !tr; n++) begin
      @(negedge clk_sys);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid === 1'b1;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
  endtask

  // poll until the period compare has been flagged
  task wait_done;
    logic [31:0] v;
    logic [1:0] rs;
    int n;
    v = 32'h0;
    for (n = 0; n < 2000 && v[2] !== 1'b1; n++) rd(dcvc_pkg::REG_IRQ_STAT, v, rs);
  endtask

  function automatic logic [7:0] vavg(input logic [1:0] m, input logic [6:0] c);
    return (m == 2'h0) ? 8'hFE - {c[5:0], 1'b0} : ((m == 2'h3) ? 8'hFF : 8'hFE) - {1'b0, c};
  endfunction

  function automatic logic isoff(input logic [1:0] m, input logic [6:0] c);
    case (m)
      2'h0: return c[5:0] == 6'h3F;
      2'h1: return c == 7'h7F;
      2'h2: return c == 7'h00;
      default: return c == 7'h00 || c == 7'h7F;
    endcase
  endfunction

  function automatic logic [7:0] clip(input int v);
    return (v < 0) ? 8'h00 : (v > 255) ? 8'hFF : 8'(v);
  endfunction

  // returns upper-check skipped, then error
  function automatic logic [1:0] errf(input logic [7:0] a, input logic [7:0] up, input logic [7:0] lo,
      input logic [7:0] k, input logic off);
    int hi;
    hi = int'(a) + int'(up);
    return {hi > 254, !off && ((hi <= 254 && int'(k) > hi) || int'(k) < int'(a) - int'(lo))};
  endfunction

  // two measured periods with the given setup, the second checked, then all results read back
  task run_case(input logic [1:0] m, input logic [5:0] c1, input logic [5:0] c2, input logic [1:0] six,
      input logic [7:0] up1, input logic [7:0] lo1, input logic [7:0] up2, input logic [7:0] lo2,
      input int k1, input int k2, input logic [2:0] en);
    logic [7:0] a1, a2, ax, bx;
    logic [1:0] e1, e2, rt, rr;
    logic [31:0] dd, ev;
    int n;
    a1 = vavg(m, {six[0], c1});
    a2 = vavg(m, {six[1], c2});
    e1 = errf(a1, up1, lo1, clip(a1 + k1), isoff(m, {six[0], c1}));
    e2 = errf(a2, up2, lo2, clip(a2 + k2), isoff(m, {six[1], c2}));
    ev = {26'h0, e2[1], e1[1], (m == 2'h0) ? six : 2'h0, e2[0], e1[0]};
    rt = 2'($random(seed));
    ax = 8'($random(seed));
    bx = 8'($random(seed));
    tgt1 <= c1;
    tgt2 <= c2;
    voltage_id_bit_six <= six;
    core1 <= clip(a1 + k1);
    core2 <= clip(a2 + k2);
    aux_a <= ax;
    aux_b <= bx;
    wr(dcvc_pkg::REG_CTRL, {27'h0, rt, m, 1'b1}, rr);
    wr(dcvc_pkg::REG_OFS1, {16'h0, lo1, up1}, rr);
    wr(dcvc_pkg::REG_OFS2, {16'h0, lo2, up2}, rr);
    wr(dcvc_pkg::REG_IRQ_EN, {29'h0, en}, rr);
    chk({30'h0, rr}, {30'h0, dcvc_pkg::RESP_OKAY});
    for (n = 0; n < 6000 && settled !== 1'b1; n++) @(posedge clk_sys);
    // the first compare after settling may still average a mixed window
    repeat (2) begin
      wr(dcvc_pkg::REG_IRQ_CLR, 32'h7, rr);
      wait_done;
    end
    rd(dcvc_pkg::REG_AVG, dd, rr);
    chk(dd, {16'h0, a2, a1});
    rd(dcvc_pkg::REG_MGMT_ERR, dd, rr);
    chk(dd, ev);
    rd(dcvc_pkg::REG_HOST_ERR, dd, rr);
    chk(dd, ev);
    rd(dcvc_pkg::REG_IRQ_STAT, dd, rr);
    chk(dd, {29'h0, 1'b1, e2[0], e1[0]});
    chk({31'h0, irq}, {31'h0, |({1'b1, e2[0], e1[0]} & en)});
    rd(dcvc_pkg::REG_AUX, dd, rr);
    chk({30'h0, fan_temp.route_b, fan_temp.route_a}, {30'h0, rt});
    chk({16'h0, fan_temp.temp_a, dd[7:0]}, {16'h0, {2{ax ^ {rt[0], 7'h00}}}});
    chk({16'h0, fan_temp.temp_b, dd[15:8]}, {16'h0, {2{bx ^ {rt[1], 7'h00}}}});
    wr(dcvc_pkg::REG_IRQ_CLR, 32'h7, rr);
    rd(dcvc_pkg::REG_IRQ_STAT, dd, rr);
    chk({dd[31:1], irq}, 32'h0);
  endtask

  // cycle ceiling against a hung handshake
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      mismatches++;
      complete_run;
    end
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    rd(dcvc_pkg::REG_CTRL, d, r);
    chk(d, 32'h0);
    rd(6'h28, d, r);
    chk({d[31:2], r}, {30'h0, dcvc_pkg::RESP_SLVERR});
    wr(6'h28, 32'h1, r);
    chk({30'h0, r}, {30'h0, dcvc_pkg::RESP_SLVERR});
    wr(dcvc_pkg::REG_AVG, 32'hFFFF, r);
    rd(dcvc_pkg::REG_AVG, d, r);
    chk(d, 32'h0);
    for (int i = 0; i < 6; i++) begin
      run_case(2'(i), 6'(1 + ($random(seed) & 3)), 6'(1 + ($random(seed) & 3)), 2'($random(seed)),
        8'($random(seed) & 15), 8'($random(seed) & 15), 8'($random(seed) & 15), 8'($random(seed) & 15),
        ($random(seed) & 31) - 16, ($random(seed) & 31) - 16, 3'($random(seed)));
    end
    // upper sum past the ceiling must not wrap into an error
    run_case(2'h0, 6'h01, 6'h00, 2'h2, 8'h0A, 8'h05, 8'h00, 8'h00, -2, -254, 3'h7);
    // an output-off code suppresses the check
    run_case(2'h2, 6'h00, 6'h00, 2'h0, 8'h00, 8'h00, 8'h00, 8'h00, -254, -254, 3'h7);
    complete_run;
  end
endmodule
